// ---- logic/ltm_consts.vh ----
`ifndef LTM_CONSTS_VH
`define LTM_CONSTS_VH

// ==================================================================
// Bus geometry
`define LTM_ADDR_W 8
`define LTM_DATA_W 32

// ==================================================================
// Register byte offsets
`define LTM_OFF_MODE 8'h00
`define LTM_OFF_FREQ_LOW 8'h04
`define LTM_OFF_FREQ_MID 8'h08
`define LTM_OFF_FREQ_HIGH 8'h0C
`define LTM_OFF_TLIM0 8'h10
`define LTM_OFF_TLIM1 8'h14
`define LTM_OFF_TLIM2 8'h18
`define LTM_OFF_TLIM3 8'h1C
`define LTM_OFF_TOL 8'h20
`define LTM_OFF_DELAY 8'h24
`define LTM_OFF_STATUS 8'h28
`define LTM_OFF_IRQ_STAT 8'h2C
`define LTM_OFF_IRQ_MASK 8'h30
`define LTM_OFF_FAULT_ACK 8'h34

// ==================================================================
// Reset values
`define LTM_RST_MODE 3'h0
`define LTM_RST_WORD16 16'h0000
`define LTM_RST_IRQ 2'h0

// ==================================================================
// Mode codes
`define LTM_MODE_OFF 3'h0
`define LTM_MODE_BELT_ALM 3'h1
`define LTM_MODE_STALL_ALM 3'h2
`define LTM_MODE_BOTH_ALM 3'h3
`define LTM_MODE_BELT_FLT 3'h4
`define LTM_MODE_STALL_FLT 3'h5
`define LTM_MODE_BOTH_FLT 3'h6

// ==================================================================
// Status word bit positions
`define LTM_ST_IN_BAND 0
`define LTM_ST_ABOVE 1
`define LTM_ST_BELOW 2
`define LTM_ST_IN_RANGE 3
`define LTM_ST_ALARM 4
`define LTM_ST_FAULT 5
`define LTM_ST_TIMING 6
`define LTM_ST_W 7

// Interrupt bit positions
`define LTM_IRQ_ALARM 0
`define LTM_IRQ_FAULT 1

// Fault acknowledge bit
`define LTM_ACK_BIT 0

// ==================================================================
// AXI responses
`define LTM_RESP_OKAY 2'h0
`define LTM_RESP_SLVERR 2'h2

// ==================================================================
// Timing: delay unit is one millisecond
`define LTM_CLK_PERIOD_NS 4
`define LTM_DELAY_UNIT_NS 1000000
`define LTM_DELAY_UNIT_CYCLES (`LTM_DELAY_UNIT_NS / `LTM_CLK_PERIOD_NS)

`endif

// ---- logic/ltm_edge_cmp.v ----
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// One band edge: piecewise linear from (fl,a) to (fm,b), flat at b
// beyond fm. Cross-multiplied so no divider is needed.
module ltm_edge_cmp (
	input wire [15:0] f,
	input wire [15:0] t,
	input wire [15:0] fl,
	input wire [15:0] fm,
	input wire signed [17:0] a,
	input wire signed [17:0] b,
	output wire above,
	output wire below
);
	wire signed [17:0] s_t;
	wire signed [18:0] dt;
	wire signed [18:0] de;
	wire signed [16:0] df;
	wire signed [16:0] dx;
	wire signed [35:0] lhs;
	wire signed [35:0] rhs;
	wire seg;

	assign s_t = {2'b00, t};
	assign dt = {s_t[17], s_t} - {a[17], a};
	assign de = {b[17], b} - {a[17], a};
	assign df = {1'b0, fm} - {1'b0, fl};
	assign dx = {1'b0, f} - {1'b0, fl};
	assign lhs = dt * df;
	assign rhs = de * dx;
	// Degenerate segment (fm <= fl) falls back to the flat edge
	assign seg = (f < fm) && (fm > fl);
	assign above = seg ? (lhs > rhs) : (s_t > b);
	assign below = seg ? (lhs < rhs) : (s_t < b);
endmodule

`default_nettype wire

// ---- logic/ltm_top.v ----
// Contract
// RULE1: Compare frequency/torque pair against band continuously
// RULE2: Mode selects alarm or fault on violation
// RULE3: Hold message off for configured delay time
// RULE4: Band from three frequencies, four torque limits
// RULE5: Upper and lower edges between frequency points
// RULE6: Modes 1/4 flag torque below band
// RULE7: Modes 2/5 flag torque above band
// RULE8: Modes 3/6 flag torque on either side
// RULE9: Monitor works in all four quadrants
// RULE10: Software sets delay longer than ramp-up time
// RULE11: Teach-in reads pairs only in steady state
// RULE12: Modes 1-3 alarm, 4-6 fault; delay restarts
// RULE13: Status word shows edge state, message-independent
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ltm_consts.vh"

module ltm_top #(
	parameter DELAY_UNIT_CYCLES = `LTM_DELAY_UNIT_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire aclken,
	input wire [`LTM_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [`LTM_DATA_W-1:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`LTM_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [`LTM_DATA_W-1:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] actual_output_frequency,
	input wire [15:0] actual_load_torque,
	output reg torque_band_alarm,
	output reg torque_band_fault,
	output reg irq
);
	localparam [17:0] UNIT_LAST = DELAY_UNIT_CYCLES[17:0] - 18'h0_0001;

	// ==================================================================
	// Configuration and bus state
	reg [2:0] torque_monitor_mode;
	reg [15:0] band_freq_point_low;
	reg [15:0] band_freq_point_mid;
	reg [15:0] band_freq_point_high;
	reg [15:0] band_torque_limit_first;
	reg [15:0] band_torque_limit_1;
	reg [15:0] band_torque_limit_2;
	reg [15:0] band_torque_limit_last;
	reg [15:0] band_torque_tolerance;
	reg [15:0] torque_monitor_delay;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg [`LTM_ADDR_W-1:0] wr_addr;
	reg [`LTM_DATA_W-1:0] wr_data;
	reg [3:0] wr_strb;

	// Monitor state
	reg [15:0] f_abs;
	reg [15:0] t_abs;
	reg edge_above;
	reg edge_below;
	reg in_range;
	reg [17:0] unit_cnt;
	reg [15:0] dly_cnt;
	reg reported;
	reg alarm_evt;
	reg fault_evt;

	wire [`LTM_ST_W-1:0] torque_monitor_status_word;
	wire do_write;
	wire fault_ack;
	wire [31:0] wmask;
	wire [31:0] merged;
	wire up_above;
	wire lo_below;
	wire signed [17:0] up_a;
	wire signed [17:0] up_b;
	wire signed [17:0] lo_a;
	wire signed [17:0] lo_b;
	reg viol;
	reg alarm_mode;
	reg [31:0] rd_data;
	reg rd_err;

	// ==================================================================
	// Register write path
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
		{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign merged = wr_data & wmask;
	assign fault_ack = do_write && (wr_addr == `LTM_OFF_FAULT_ACK) &&
		wr_strb[0] && wr_data[`LTM_ACK_BIT];

	// Byte lanes above bit 15 are ignored: all fields are 16 bits or less
	function [15:0] lane16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] st;
		begin
			lane16[7:0] = st[0] ? wd[7:0] : old[7:0];
			lane16[15:8] = st[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	function wr_map;
		input [`LTM_ADDR_W-1:0] ad;
		begin
			wr_map = (ad[1:0] == 2'b00) && (ad <= `LTM_OFF_FAULT_ACK) &&
				(ad != `LTM_OFF_STATUS);
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LTM_RESP_OKAY;
			wr_addr <= {`LTM_ADDR_W{1'b0}};
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			torque_monitor_mode <= `LTM_RST_MODE;
			band_freq_point_low <= `LTM_RST_WORD16;
			band_freq_point_mid <= `LTM_RST_WORD16;
			band_freq_point_high <= `LTM_RST_WORD16;
			band_torque_limit_first <= `LTM_RST_WORD16;
			band_torque_limit_1 <= `LTM_RST_WORD16;
			band_torque_limit_2 <= `LTM_RST_WORD16;
			band_torque_limit_last <= `LTM_RST_WORD16;
			band_torque_tolerance <= `LTM_RST_WORD16;
			torque_monitor_delay <= `LTM_RST_WORD16;
			irq_stat <= `LTM_RST_IRQ;
			irq_mask <= `LTM_RST_IRQ;
			irq <= 1'b0;
		end else if (aclken) begin
			if (s_axi_awready && s_axi_awvalid) begin
				s_axi_awready <= 1'b0;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				s_axi_wready <= 1'b0;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map(wr_addr) ? `LTM_RESP_OKAY :
					`LTM_RESP_SLVERR;
				case (wr_addr)
				`LTM_OFF_MODE: if (wr_strb[0])
					torque_monitor_mode <= wr_data[2:0];
				`LTM_OFF_FREQ_LOW: band_freq_point_low <=
					lane16(band_freq_point_low, wr_data, wr_strb);
				`LTM_OFF_FREQ_MID: band_freq_point_mid <=
					lane16(band_freq_point_mid, wr_data, wr_strb);
				`LTM_OFF_FREQ_HIGH: band_freq_point_high <=
					lane16(band_freq_point_high, wr_data, wr_strb);
				`LTM_OFF_TLIM0: band_torque_limit_first <=
					lane16(band_torque_limit_first, wr_data, wr_strb);
				`LTM_OFF_TLIM1: band_torque_limit_1 <=
					lane16(band_torque_limit_1, wr_data, wr_strb);
				`LTM_OFF_TLIM2: band_torque_limit_2 <=
					lane16(band_torque_limit_2, wr_data, wr_strb);
				`LTM_OFF_TLIM3: band_torque_limit_last <=
					lane16(band_torque_limit_last, wr_data, wr_strb);
				`LTM_OFF_TOL: band_torque_tolerance <=
					lane16(band_torque_tolerance, wr_data, wr_strb);
				`LTM_OFF_DELAY: torque_monitor_delay <=
					lane16(torque_monitor_delay, wr_data, wr_strb);
				`LTM_OFF_IRQ_MASK: if (wr_strb[0])
					irq_mask <= wr_data[1:0];
				default: begin
				end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			// Set wins over a write-one clear in the same cycle
			irq_stat[`LTM_IRQ_ALARM] <= alarm_evt ||
				(irq_stat[`LTM_IRQ_ALARM] && !(do_write &&
				wr_addr == `LTM_OFF_IRQ_STAT &&
				merged[`LTM_IRQ_ALARM]));
			irq_stat[`LTM_IRQ_FAULT] <= fault_evt ||
				(irq_stat[`LTM_IRQ_FAULT] && !(do_write &&
				wr_addr == `LTM_OFF_IRQ_STAT &&
				merged[`LTM_IRQ_FAULT]));
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ==================================================================
	// Register read path
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		case (s_axi_araddr)
		`LTM_OFF_MODE: rd_data = {29'h0, torque_monitor_mode};
		`LTM_OFF_FREQ_LOW: rd_data = {16'h0000, band_freq_point_low};
		`LTM_OFF_FREQ_MID: rd_data = {16'h0000, band_freq_point_mid};
		`LTM_OFF_FREQ_HIGH: rd_data = {16'h0000, band_freq_point_high};
		`LTM_OFF_TLIM0: rd_data = {16'h0000, band_torque_limit_first};
		`LTM_OFF_TLIM1: rd_data = {16'h0000, band_torque_limit_1};
		`LTM_OFF_TLIM2: rd_data = {16'h0000, band_torque_limit_2};
		`LTM_OFF_TLIM3: rd_data = {16'h0000, band_torque_limit_last};
		`LTM_OFF_TOL: rd_data = {16'h0000, band_torque_tolerance};
		`LTM_OFF_DELAY: rd_data = {16'h0000, torque_monitor_delay};
		`LTM_OFF_STATUS: rd_data = {25'h0, torque_monitor_status_word};
		`LTM_OFF_IRQ_STAT: rd_data = {30'h0, irq_stat};
		`LTM_OFF_IRQ_MASK: rd_data = {30'h0, irq_mask};
		`LTM_OFF_FAULT_ACK: rd_data = 32'h0000_0000;
		default: rd_err = 1'b1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LTM_RESP_OKAY;
		end else if (aclken) begin
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? `LTM_RESP_SLVERR : `LTM_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Band edges, tolerance widening both sides
	assign up_a = {2'b00, band_torque_limit_first} +
		{2'b00, band_torque_tolerance}; // RULE4
	assign up_b = {2'b00, band_torque_limit_1} +
		{2'b00, band_torque_tolerance}; // RULE4
	assign lo_a = {2'b00, band_torque_limit_2} -
		{2'b00, band_torque_tolerance}; // RULE4
	assign lo_b = {2'b00, band_torque_limit_last} -
		{2'b00, band_torque_tolerance}; // RULE4

	ltm_edge_cmp u_upper (
		.f(f_abs),
		.t(t_abs),
		.fl(band_freq_point_low),
		.fm(band_freq_point_mid),
		.a(up_a),
		.b(up_b),
		.above(up_above),
		.below()
	); // RULE5

	ltm_edge_cmp u_lower (
		.f(f_abs),
		.t(t_abs),
		.fl(band_freq_point_low),
		.fm(band_freq_point_mid),
		.a(lo_a),
		.b(lo_b),
		.above(),
		.below(lo_below)
	); // RULE5

	assign torque_monitor_status_word = {reported && viol,
		torque_band_fault, torque_band_alarm, in_range, edge_below,
		edge_above, in_range && !edge_above && !edge_below}; // RULE13

	// ==================================================================
	// Violation by mode; only the selected side counts
	always @* begin
		viol = 1'b0;
		alarm_mode = 1'b0;
		case (torque_monitor_mode)
		`LTM_MODE_BELT_ALM: begin
			viol = edge_below; // RULE6
			alarm_mode = 1'b1; // RULE12
		end
		`LTM_MODE_STALL_ALM: begin
			viol = edge_above; // RULE7
			alarm_mode = 1'b1; // RULE12
		end
		`LTM_MODE_BOTH_ALM: begin
			viol = edge_above || edge_below; // RULE8
			alarm_mode = 1'b1; // RULE12
		end
		`LTM_MODE_BELT_FLT: viol = edge_below; // RULE6
		`LTM_MODE_STALL_FLT: viol = edge_above; // RULE7
		`LTM_MODE_BOTH_FLT: viol = edge_above || edge_below; // RULE8
		default: viol = 1'b0;
		endcase
	end

	// ==================================================================
	// Sampling, delay and messages
	always @(posedge aclk) begin
		if (!aresetn) begin
			f_abs <= 16'h0000;
			t_abs <= 16'h0000;
			edge_above <= 1'b0;
			edge_below <= 1'b0;
			in_range <= 1'b0;
			unit_cnt <= 18'h0_0000;
			dly_cnt <= 16'h0000;
			reported <= 1'b0;
			alarm_evt <= 1'b0;
			fault_evt <= 1'b0;
			torque_band_alarm <= 1'b0;
			torque_band_fault <= 1'b0;
		end else if (aclken) begin
			// Magnitudes fold the four quadrants onto one
			f_abs <= actual_output_frequency[15] ?
				16'h0000 - actual_output_frequency :
				actual_output_frequency; // RULE9
			t_abs <= actual_load_torque[15] ?
				16'h0000 - actual_load_torque :
				actual_load_torque; // RULE9
			// Outside the frequency window nothing is judged
			in_range <= (f_abs >= band_freq_point_low) &&
				(f_abs <= band_freq_point_high); // RULE1
			edge_above <= up_above && (f_abs >= band_freq_point_low) &&
				(f_abs <= band_freq_point_high); // RULE1
			edge_below <= lo_below && (f_abs >= band_freq_point_low) &&
				(f_abs <= band_freq_point_high); // RULE1
			alarm_evt <= 1'b0;
			fault_evt <= 1'b0;
			if (!viol) begin
				unit_cnt <= 18'h0_0000; // RULE12
				dly_cnt <= 16'h0000; // RULE12
				reported <= 1'b0;
				torque_band_alarm <= 1'b0;
			end else if (!reported) begin
				if (dly_cnt >= torque_monitor_delay) begin // RULE3
					reported <= 1'b1;
					if (alarm_mode) begin
						torque_band_alarm <= 1'b1; // RULE2
						alarm_evt <= 1'b1;
					end else begin
						torque_band_fault <= 1'b1; // RULE2
						fault_evt <= 1'b1;
					end
				end else if (unit_cnt == UNIT_LAST) begin
					unit_cnt <= 18'h0_0000; // RULE3
					dly_cnt <= dly_cnt + 16'h0001; // RULE3
				end else begin
					unit_cnt <= unit_cnt + 18'h0_0001; // RULE3
				end
			end
			// Trip stays latched until acknowledged; a new trip wins
			if (fault_ack && !(viol && !reported && !alarm_mode &&
				dly_cnt >= torque_monitor_delay))
				torque_band_fault <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// ---- verification/ltm_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ltm_tb_top;
	// ==================================================================
	// Stimulus and outputs
	logic aclk = 1'b0, aresetn = 1'b0, aclken = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [15:0] actual_output_frequency = 16'h0000;
	logic [15:0] actual_load_torque = 16'h0000;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, torque_band_alarm, torque_band_fault, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int failures = 0, compares = 0;
	int m, k, f, t, ab, be, inr, e, al, fl;
	int fv[7] = '{300, 300, 300, 300, 300, 100, 50};
	int tv[7] = '{0, 99, 100, 501, 500, 400, 600};
	int cfg[9] = '{100, 200, 400, 300, 480, 120, 120, 20, 0};
	logic [31:0] rnd = 32'h0000_0037;

	ltm_top #(.DELAY_UNIT_CYCLES(4)) u_dut (
		.aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .actual_output_frequency,
		.actual_load_torque, .torque_band_alarm, .torque_band_fault, .irq
	);

	initial begin
		forever #2 aclk = ~aclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] y;
		y = v ^ (v << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x,
			input string s);
		compares++;
		if (g !== x) begin
			failures++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, s, g, x);
		end
	endtask

	// ==================================================================
	// Register bus master; rready raised late so the slave must hold rvalid; bready rises with bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] xr);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// Waits as long as the slave needs; only the watchdog ends a hang
		while (n != 90) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				chk(s_axi_bresp, xr, "bresp");
				s_axi_bready <= 1'b0;
				n = 90;
			end else if (!s_axi_awvalid && !s_axi_wvalid) begin
				s_axi_bready <= 1'b1;
			end
		end
		@(posedge aclk);
		chk(s_axi_bvalid, 0, "bvalid drop");
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] x,
			input logic [1:0] xr);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (n != 90) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				chk(s_axi_rdata, x, "rdata");
				chk(s_axi_rresp, xr, "rresp");
				s_axi_rready <= 1'b0;
				n = 90;
			end else if (!s_axi_arvalid) begin
				s_axi_rready <= 1'b1;
			end
		end
		@(posedge aclk);
		chk(s_axi_rvalid, 0, "rvalid drop");
	endtask

	task automatic drv(input int fq, input int tq, input int n);
		actual_output_frequency <= fq[15:0];
		actual_load_torque <= tq[15:0];
		repeat (n) @(posedge aclk);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#150000;
		failures++;
		give_verdict();
	end

	// ==================================================================
	// Test sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(8'h00, 0, 2'h0);
		rdc(8'h30, 0, 2'h0);
		rdc(8'h3C, 0, 2'h2);
		wr(8'h28, 1, 2'h2);
		for (k = 0; k < 9; k++) wr(8'h04 + 8'(4 * k), cfg[k], 2'h0);
		wr(8'h30, 3, 2'h0);
		rdc(8'h08, 200, 2'h0);
		rdc(8'h34, 0, 2'h0);
		$display("test registers done");
		// Band edge: upper 500 flat from 200, sloping to 320 at 100
		for (m = 1; m <= 6; m++) begin
			wr(8'h00, m, 2'h0);
			for (k = 0; k < 7; k++) begin
				rnd = xs(rnd);
				if (k == 0) tv[0] = 100 + rnd[15:8];
				f = rnd[0] ? -fv[k] : fv[k];
				t = rnd[1] ? -tv[k] : tv[k];
				drv(f, t, 8);
				ab = tv[k] > ((fv[k] >= 200) ? 500 : 320 + (fv[k] - 100) * 9 / 5);
				be = tv[k] < 100;
				inr = fv[k] >= 100 && fv[k] <= 400;
				e = inr && ((m % 3 == 1) ? be : (m % 3 == 2) ? ab : ab || be);
				al = m < 4 && e;
				fl = m >= 4 && e;
				chk(torque_band_alarm, al, "alarm");
				chk(torque_band_fault, fl, "fault");
				chk(irq, e, "irq");
				if (inr) rdc(8'h28, (e << 6) | (fl << 5) | (al << 4) | 8 |
					(be << 2) | (ab << 1) | (!ab && !be), 2'h0);
				drv(300, 300, 8);
				chk(torque_band_alarm, 0, "alarm clear");
				wr(8'h34, 1, 2'h0);
				wr(8'h2C, 3, 2'h0);
				chk(torque_band_fault, 0, "fault ack");
				chk(irq, 0, "irq clear");
			end
			$display("test mode %0d done", m);
		end
		// Clock enable low freezes the monitor; mode 7 is off
		wr(8'h00, 3, 2'h0);
		aclken <= 1'b0;
		drv(300, 600, 8);
		chk(torque_band_alarm, 0, "alarm frozen");
		aclken <= 1'b1;
		drv(300, 600, 8);
		chk(torque_band_alarm, 1, "alarm enabled");
		wr(8'h00, 7, 2'h0);
		drv(300, 600, 8);
		chk(torque_band_alarm, 0, "alarm mode off");
		chk(torque_band_fault, 0, "fault mode off");
		wr(8'h2C, 3, 2'h0);
		$display("test enable done");
		// Delay of two units, interrupt masked
		wr(8'h30, 0, 2'h0);
		wr(8'h24, 2, 2'h0);
		wr(8'h00, 1, 2'h0);
		drv(300, 50, 6);
		chk(torque_band_alarm, 0, "alarm early");
		drv(300, 50, 10);
		chk(torque_band_alarm, 1, "alarm delayed");
		chk(irq, 0, "irq masked");
		rdc(8'h2C, 1, 2'h0);
		wr(8'h2C, 1, 2'h0);
		rdc(8'h2C, 0, 2'h0);
		drv(300, 300, 8);
		drv(300, 50, 8);
		drv(300, 300, 4);
		drv(300, 50, 8);
		chk(torque_band_alarm, 0, "delay restart");
		drv(300, 50, 8);
		chk(torque_band_alarm, 1, "alarm after restart");
		$display("test delay done");
		// Reset in mid-run drops the message and the configuration
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(8'h00, 0, 2'h0);
		chk(torque_band_alarm, 0, "alarm after reset");
		$display("test reset done");
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- verification/ltm_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Message and register bus checks on the top-level pins
module ltm_top_asserts #(
	parameter DELAY_UNIT_CYCLES = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic aclken,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic torque_band_alarm,
	input wire logic torque_band_fault
);
	logic [2:0] mode_q;
	// Nothing is taken while the clock enable is low
	wire aw_go = aclken && s_axi_awvalid && s_axi_awready;
	wire w_go = aclken && s_axi_wvalid && s_axi_wready;
	wire ack_go = aw_go && w_go && s_axi_awaddr == 8'h34 && s_axi_wdata[0];

	// Shadow of the mode field, taken from bus writes
	always @(posedge aclk) begin
		if (!aresetn)
			mode_q <= 3'h0;
		else if (aw_go && w_go && s_axi_awaddr == 8'h00)
			mode_q <= s_axi_wdata[2:0];
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !aclken);

	property p_alarm_mode;
		$rose(torque_band_alarm) |-> mode_q inside {3'h1, 3'h2, 3'h3};
	endproperty
	a_alarm_mode: assert property (p_alarm_mode)
		else $error("alarm raised outside an alarm mode");
	property p_fault_mode;
		$rose(torque_band_fault) |-> mode_q inside {3'h4, 3'h5, 3'h6};
	endproperty
	a_fault_mode: assert property (p_fault_mode)
		else $error("fault raised outside a fault mode");
	property p_fault_latch;
		$fell(torque_band_fault) |->
			$past(ack_go) || $past(ack_go, 2) || $past(ack_go, 3);
	endproperty
	a_fault_latch: assert property (p_fault_latch)
		else $error("fault dropped without acknowledge");
	property p_one_kind;
		$rose(torque_band_alarm) |-> !$rose(torque_band_fault);
	endproperty
	a_one_kind: assert property (p_one_kind)
		else $error("alarm and fault raised together");
	property p_wr_resp;
		aw_go && w_go |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write response late");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response not held");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read response not held");
	property p_aw_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_busy: assert property (p_aw_busy)
		else $error("write channel ready while response pending");

	c_alarm: cover property ($rose(torque_band_alarm));
	c_fault: cover property ($rose(torque_band_fault));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind ltm_top ltm_top_asserts #(
	.DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)
) u_chk (
	.aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .torque_band_alarm, .torque_band_fault
);
`default_nettype wire
